// File: src/word_codec_pkg.sv
// shared constants, types and register map of the command/response word codec
package word_codec_pkg;

   // bit and word timing at the 40 ns system clock
   localparam int CLK_NS       = 40;
   localparam int BIT_NS       = 1000;
   localparam int SYNC_HALF_NS = 1500;
   localparam int SYNC_MIN_NS  = 1200;
   localparam int SYNC_MAX_NS  = 2200;
   localparam int RESP_MIN_NS  = 4000;
   localparam int RESP_MAX_NS  = 12000;

   localparam logic [4:0] BIT_CYC       = 5'(BIT_NS / CLK_NS);
   localparam logic [4:0] HALF_CYC      = 5'(BIT_NS / CLK_NS / 2);
   localparam logic [4:0] Q1_CYC        = 5'(BIT_NS / CLK_NS / 4);
   localparam logic [4:0] Q3_CYC        = 5'(BIT_NS * 3 / CLK_NS / 4);
   localparam logic [5:0] SYNC_HALF_CYC = 6'(SYNC_HALF_NS / CLK_NS);
   localparam logic [5:0] SYNC_CHK_CYC  = 6'(SYNC_HALF_NS / CLK_NS / 2);
   localparam logic [4:0] SYNC_TAIL_CYC = 5'(SYNC_HALF_NS / CLK_NS - BIT_NS / CLK_NS);
   localparam logic [5:0] SYNC_MIN_CYC  = 6'((SYNC_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [5:0] SYNC_MAX_CYC  = 6'(SYNC_MAX_NS / CLK_NS);
   localparam logic [8:0] RESP_MIN_CYC  = 9'((RESP_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [8:0] RESP_MAX_CYC  = 9'(RESP_MAX_NS / CLK_NS);

   // word layout
   localparam int         WORD_BITS_N = 20;
   localparam logic [4:0] SYNC_BITS   = 5'd3;
   localparam logic [4:0] PARITY_IDX  = 5'd16;
   localparam logic [4:0] LAST_BIT    = 5'(WORD_BITS_N - 1);
   localparam int         WORD_CYC    = WORD_BITS_N * (BIT_NS / CLK_NS);

   // command fields
   localparam logic [4:0] BCAST_ADDR  = 5'h1f;
   localparam logic [4:0] MODE_SA_LO  = 5'h00;
   localparam logic [4:0] MODE_SA_HI  = 5'h1f;
   localparam logic [5:0] MAX_WC      = 6'h20;

   // register map, byte offsets
   localparam logic [3:0] REG_CTRL    = 4'h0;
   localparam logic [3:0] REG_COND    = 4'h4;
   localparam logic [3:0] REG_STATUS  = 4'h8;
   localparam logic [3:0] REG_LASTCMD = 4'hc;
   localparam int         CTRL_ADDR_MSB = 4;
   localparam int         CTRL_EN_BIT   = 5;
   localparam int         COND_MSB      = 4;
   localparam int         COND_SR       = 0;
   localparam int         COND_BUSY     = 1;
   localparam int         COND_SSF      = 2;
   localparam int         COND_TF       = 3;
   localparam int         COND_DBCA     = 4;
   localparam logic [4:0] CTRL_ADDR_RST = 5'h00;
   localparam logic [4:0] COND_RST      = 5'h00;

   typedef struct packed {
      logic [15:0] data;
      logic        sync_cmd;
      logic        parity_ok;
      logic        manch_err;
   } rx_word_s;

   typedef struct packed {
      logic [15:0] data;
      logic        sync_cmd;
   } tx_word_s;

   typedef struct packed {
      logic [4:0] addr;
      logic       transmit;
      logic [4:0] subaddr;
      logic       mode;
      logic [5:0] count;
      logic [4:0] mode_code;
      logic       broadcast;
   } cmd_s;

endpackage

// File: src/word_codec.sv
// terminal-side Manchester word codec with command parsing and status word logic
// Summary of operation
// R01: each word is 20 bit times: 3 sync, 16 information bits, odd parity bit.
// R02: Manchester bi-phase; one is high-then-low, zero is low-then-high, mid-bit transition.
// R03: every received word reports its sync type and whether parity was valid; the terminal's own echo is decoded but not reported.
// R04: encoder sends the requested sync and appends odd parity itself.
// R05: command bits 4-8 are terminal address, bit 9 selects receive or transmit.
// R06: subaddress 00000 or 11111 marks a mode command, others address subsystem.
// R07: word count field of zero means 32; mode commands carry a mode code there.
// R08: data words use the inverted sync of command and status words.
// R09: sixteen information bits travel most significant bit first.
// R10: valid command clears status, then still-present conditions set their bits again.
// R11: message error sets bit 9, data is discarded and status is withheld.
// R12: status bits 4 to 8 carry the terminal's programmed address.
// R13: instrumentation bit 10 is always sent as zero in status.
// R14: service request bit 11 set when terminal needs controller service.
// R15: reserved status bits 12 to 14 are sent as zero.
// R16: valid broadcast sets bit 15 and suppresses the status response.
// R17: busy bit 16 reports terminal cannot move data to its subsystem.
// R18: bit 17 reports a subsystem fault.
// R19: bit 18 reports accepted bus control after the matching mode code.
// R20: terminal flag bit 19 reports a fault in terminal hardware.
// R21: mode command may bring one data word; terminal answers with status.
// R22: respond as terminal only to own address, otherwise only monitor words.
// R23: response starts 4 to 12 us after the command; later counts as none.
// R24: terminal address 31 is broadcast: data accepted, no status returned.
// R25: command sync is 1.5 us low then 1.5 us high, data sync inverted.
// R26: single synchronous clock; reset clears decoder, encoder and status bits.
// R27: a bit cell without mid-bit transition is a Manchester error, word invalid.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
module word_codec
   import word_codec_pkg::*;
#(
   parameter logic [4:0] DBC_MODE_CODE = 5'h02
)(
   input  logic        clk,
   input  logic        rst_n,
   input  logic        rx_hi,
   input  logic        rx_lo,
   output logic        tx_hi,
   output logic        tx_lo,
   output logic        tx_drive,
   input  logic [3:0]  reg_addr,
   input  logic [31:0] reg_wdata,
   input  logic        reg_wr,
   input  logic        reg_rd,
   output logic [31:0] reg_rdata,
   input  logic        host_tx_valid,
   input  tx_word_s    host_tx,
   output logic        host_tx_ready,
   output logic        rx_valid,
   output rx_word_s    rx_word,
   output logic        cmd_valid,
   output cmd_s        cmd,
   output logic        data_valid,
   output logic [15:0] data_word,
   output logic        msg_done,
   output logic        msg_error,
   output logic        bus_ctrl_taken
);

   typedef enum logic [1:0] {D_IDLE = 2'b00, D_SYNC2 = 2'b01, D_BITS = 2'b10} dec_state_e;
   typedef enum logic [1:0] {M_IDLE = 2'b00, M_RXDATA = 2'b01, M_GAP = 2'b10, M_RESP = 2'b11} msg_state_e;

   // ---------------- registers ----------------
   logic [4:0]  own_addr;
   logic        rt_enable;
   logic [4:0]  cond;
   logic [15:0] last_cmd;
   logic        last_bcast;
   logic [15:0] status_word;
   logic [31:0] rd_value;
   dec_state_e  d_state;
   msg_state_e  m_state;

   assign rd_value = (reg_addr == REG_CTRL)    ? {26'h0, rt_enable, own_addr} :
                     (reg_addr == REG_COND)    ? {27'h0, cond} :
                     (reg_addr == REG_STATUS)  ? {13'h0, d_state != D_IDLE, m_state, status_word} :
                     (reg_addr == REG_LASTCMD) ? {15'h0, last_bcast, last_cmd} : 32'h0;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         own_addr  <= CTRL_ADDR_RST;
         rt_enable <= 1'b0;
         cond      <= COND_RST;
         reg_rdata <= 32'h0;
      end else begin
         if (reg_wr && reg_addr == REG_CTRL) begin
            own_addr  <= reg_wdata[CTRL_ADDR_MSB:0];
            rt_enable <= reg_wdata[CTRL_EN_BIT];
         end
         if (reg_wr && reg_addr == REG_COND) begin
            cond <= reg_wdata[COND_MSB:0];
         end
         reg_rdata <= reg_rd ? rd_value : 32'h0;
      end
   end

   // ---------------- decoder ----------------
   logic        rx_hi_m, rx_hi_s, rx_lo_m, rx_lo_s;
   logic        prev_lvl, prev_act;
   logic [5:0]  rcnt, dcnt;
   logic [4:0]  d_bc, d_bi;
   logic        d_h1, d_err, d_cmd, d_echo;
   logic [16:0] d_sh;
   logic        tx_en;
   logic        lvl, act, rx_edge;

   // only one line asserted is a driven bus; both low is idle
   assign lvl     = rx_hi_s;
   assign act     = rx_hi_s ^ rx_lo_s;
   assign rx_edge = act & prev_act & (lvl != prev_lvl);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rx_hi_m <= 1'b0;
         rx_hi_s <= 1'b0;
         rx_lo_m <= 1'b0;
         rx_lo_s <= 1'b0;
         prev_lvl <= 1'b0;
         prev_act <= 1'b0;
         rcnt <= 6'h00;
         dcnt <= 6'h00;
         d_bc <= 5'h00;
         d_bi <= 5'h00;
         d_h1 <= 1'b0;
         d_err <= 1'b0;
         d_cmd <= 1'b0;
         d_echo <= 1'b0;
         d_sh <= 17'h0;
         d_state <= D_IDLE; // R26
         rx_valid <= 1'b0;
         rx_word <= '0;
      end else begin
         rx_hi_m <= rx_hi;
         rx_hi_s <= rx_hi_m;
         rx_lo_m <= rx_lo;
         rx_lo_s <= rx_lo_m;
         prev_lvl <= lvl;
         prev_act <= act;
         rx_valid <= 1'b0;
         // a run longer than any Manchester half pair can only be a sync half
         rcnt <= (!act || rx_edge) ? 6'h00 : ((rcnt == 6'h3f) ? rcnt : rcnt + 6'h01);
         case (d_state)
            D_IDLE: begin
               if (rx_edge && rcnt >= SYNC_MIN_CYC && rcnt <= SYNC_MAX_CYC) begin // R25
                  d_state <= D_SYNC2;
                  d_cmd <= ~prev_lvl; // R08
                  d_echo <= tx_en;
                  dcnt <= 6'h00;
               end
            end
            D_SYNC2: begin
               dcnt <= dcnt + 6'h01;
               if (!act || (dcnt == SYNC_CHK_CYC && lvl != d_cmd)) begin
                  d_state <= D_IDLE;
               end else if (dcnt == SYNC_HALF_CYC - 6'h01) begin
                  d_state <= D_BITS;
                  d_bc <= 5'h00;
                  d_bi <= 5'h00;
                  d_err <= 1'b0;
               end
            end
            D_BITS: begin
               d_bc <= d_bc + 5'h01;
               if (d_bc == Q1_CYC) begin
                  d_h1 <= lvl;
               end
               if (d_bc == Q3_CYC) begin
                  d_sh <= {d_sh[15:0], d_h1}; // R02 R09
                  if (lvl == d_h1 || !act) begin
                     d_err <= 1'b1; // R27
                  end
               end
               if (d_bc == BIT_CYC - 5'h01) begin
                  d_bc <= 5'h00;
                  d_bi <= d_bi + 5'h01;
                  if (d_bi == PARITY_IDX) begin
                     d_state <= D_IDLE;
                     // our own echo is not handed on
                     rx_valid <= ~d_echo;
                     rx_word <= '{data: d_sh[16:1], sync_cmd: d_cmd, parity_ok: ^d_sh, manch_err: d_err}; // R03
                  end
               end
            end
            default: d_state <= D_IDLE;
         endcase
      end
   end

   // ---------------- command parsing ----------------
   logic [4:0] rx_addr, rx_sa, rx_wc;
   logic       rx_tr, word_ok, is_mode, is_bcast, cmd_hit, is_data, bad_word;
   logic [5:0] need;

   assign rx_addr  = rx_word.data[15:11]; // R05
   assign rx_tr    = rx_word.data[10];
   assign rx_sa    = rx_word.data[9:5];
   assign rx_wc    = rx_word.data[4:0];
   assign word_ok  = rx_valid & rx_word.parity_ok & ~rx_word.manch_err; // R27
   assign is_mode  = (rx_sa == MODE_SA_LO) | (rx_sa == MODE_SA_HI); // R06
   assign is_bcast = rx_addr == BCAST_ADDR; // R24
   // other addresses are only passed on as monitored words
   assign cmd_hit  = word_ok & rx_word.sync_cmd & rt_enable & (rx_addr == own_addr | is_bcast) &
                     (m_state != M_RESP); // R22
   // receive mode codes with the top bit set carry one data word toward the terminal
   assign need     = is_mode ? {5'h00, ~rx_tr & rx_wc[4]} :
                     (rx_tr ? 6'h00 : ((rx_wc == 5'h00) ? MAX_WC : {1'b0, rx_wc})); // R07 R21
   assign is_data  = word_ok & ~rx_word.sync_cmd & (m_state == M_RXDATA);
   assign bad_word = rx_valid & (m_state == M_RXDATA) & ~cmd_hit & ~is_data;

   // ---------------- status word ----------------
   logic st_me, st_sr, st_bcr, st_busy, st_ssf, st_dbca, st_tf;

   assign status_word = {own_addr, st_me, 1'b0, st_sr, 3'b000, st_bcr, st_busy, st_ssf, st_dbca, st_tf}; // R12 R13 R15
   assign bus_ctrl_taken = st_dbca; // R19

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_me <= 1'b0;
         st_sr <= 1'b0;
         st_bcr <= 1'b0;
         st_busy <= 1'b0;
         st_ssf <= 1'b0;
         st_dbca <= 1'b0;
         st_tf <= 1'b0; // R26
      end else if (cmd_hit) begin
         // cleared by the command, live conditions set their bits at once
         st_me <= 1'b0; // R10
         st_bcr <= is_bcast; // R16
         st_sr <= cond[COND_SR]; // R14
         st_busy <= cond[COND_BUSY]; // R17
         st_ssf <= cond[COND_SSF]; // R18
         st_tf <= cond[COND_TF]; // R20
         st_dbca <= is_mode & (rx_wc == DBC_MODE_CODE) & cond[COND_DBCA]; // R19
      end else begin
         st_me <= st_me | bad_word; // R11
         st_sr <= st_sr | cond[COND_SR];
         st_busy <= st_busy | cond[COND_BUSY];
         st_ssf <= st_ssf | cond[COND_SSF];
         st_tf <= st_tf | cond[COND_TF];
      end
   end

   // ---------------- message sequencing ----------------
   logic [5:0] remain;
   logic [8:0] gcnt;
   logic       enc_free, load_status, load_host, load;

   assign load_status   = (m_state == M_RESP) & enc_free;
   assign host_tx_ready = enc_free & (m_state == M_IDLE);
   assign load_host     = host_tx_valid & host_tx_ready;
   assign load          = load_status | load_host;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         m_state <= M_IDLE;
         remain <= 6'h00;
         gcnt <= 9'h000;
         cmd_valid <= 1'b0;
         cmd <= '0;
         last_cmd <= 16'h0;
         last_bcast <= 1'b0;
         data_valid <= 1'b0;
         data_word <= 16'h0;
         msg_done <= 1'b0;
         msg_error <= 1'b0;
      end else begin
         cmd_valid <= cmd_hit;
         data_valid <= 1'b0;
         msg_done <= 1'b0;
         msg_error <= 1'b0;
         if (cmd_hit) begin
            cmd <= '{addr: rx_addr, transmit: rx_tr, subaddr: rx_sa, mode: is_mode,
                     count: is_mode ? 6'h00 : ((rx_wc == 5'h00) ? MAX_WC : {1'b0, rx_wc}),
                     mode_code: is_mode ? rx_wc : 5'h00, broadcast: is_bcast}; // R05 R06 R07
            last_cmd <= rx_word.data;
            last_bcast <= is_bcast;
            remain <= need;
            gcnt <= 9'h000;
            m_state <= (need != 6'h00) ? M_RXDATA : M_GAP;
         end else begin
            case (m_state)
               M_RXDATA: begin
                  if (is_data) begin
                     data_valid <= 1'b1;
                     data_word <= rx_word.data;
                     remain <= remain - 6'h01;
                     if (remain == 6'h01) begin
                        m_state <= M_GAP;
                        gcnt <= 9'h000;
                     end
                  end else if (bad_word) begin
                     m_state <= M_GAP;
                     gcnt <= 9'h000;
                  end
               end
               M_GAP: begin
                  gcnt <= gcnt + 9'h001;
                  if (st_me || st_bcr) begin
                     // no answer; host drops the words when msg_error is set
                     m_state <= M_IDLE; // R11 R16 R24
                     msg_done <= 1'b1;
                     msg_error <= st_me;
                  end else if (gcnt == RESP_MIN_CYC - 9'h001) begin
                     m_state <= M_RESP; // R23
                  end
               end
               M_RESP: begin
                  if (enc_free) begin
                     m_state <= M_IDLE;
                     msg_done <= 1'b1;
                  end
               end
               default: m_state <= M_IDLE;
            endcase
         end
      end
   end

   // ---------------- encoder ----------------
   logic [4:0]  tx_bc, tx_bi;
   logic [16:0] tx_word;
   logic        tx_cmd, sync_first, enc_lvl;
   tx_word_s    next_word;

   // next word may load in the last cycle so words follow with no gap
   assign enc_free   = ~tx_en | (tx_bi == LAST_BIT & tx_bc == BIT_CYC - 5'h01);
   assign next_word  = load_status ? '{data: status_word, sync_cmd: 1'b1} : host_tx;
   assign sync_first = (tx_bi == 5'h00) | (tx_bi == 5'h01 & tx_bc < SYNC_TAIL_CYC);
   assign enc_lvl    = (tx_bi < SYNC_BITS) ? (tx_cmd ^ sync_first) : (tx_word[16] ^ (tx_bc >= HALF_CYC)); // R02 R25

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_en <= 1'b0; // R26
         tx_bc <= 5'h00;
         tx_bi <= 5'h00;
         tx_word <= 17'h0;
         tx_cmd <= 1'b0;
         tx_hi <= 1'b0;
         tx_lo <= 1'b0;
         tx_drive <= 1'b0;
      end else begin
         tx_hi <= tx_en & enc_lvl;
         tx_lo <= tx_en & ~enc_lvl;
         tx_drive <= tx_en;
         if (load) begin
            tx_en <= 1'b1;
            tx_bc <= 5'h00;
            tx_bi <= 5'h00;
            tx_word <= {next_word.data, ~^next_word.data}; // R04
            tx_cmd <= next_word.sync_cmd; // R04 R08
         end else if (tx_en) begin
            if (tx_bc == BIT_CYC - 5'h01) begin
               tx_bc <= 5'h00;
               tx_bi <= tx_bi + 5'h01;
               if (tx_bi >= SYNC_BITS) begin
                  tx_word <= {tx_word[15:0], 1'b0}; // R09
               end
               if (tx_bi == LAST_BIT) begin
                  tx_en <= 1'b0; // R01
               end
            end else begin
               tx_bc <= tx_bc + 5'h01;
            end
         end
      end
   end

   // ---------------- checks ----------------
   logic [15:0] tx_len;
   logic [8:0]  quiet;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_len <= 16'h0;
         quiet <= 9'h000;
      end else begin
         tx_len <= tx_en ? tx_len + 16'h1 : 16'h0;
         quiet <= rx_valid ? 9'h000 : ((quiet == 9'h1ff) ? quiet : quiet + 9'h001);
      end
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_word_len;
      $fell(tx_en) |-> (tx_len != 16'h0) && (int'(tx_len) % WORD_CYC == 0);
   endproperty
   a_word_len: assert property (p_word_len) else $error("word length not a multiple of 20 bit times"); // R01

   property p_mid_edge;
      tx_en && tx_bi >= SYNC_BITS && tx_bc == HALF_CYC |=> tx_hi != $past(tx_hi);
   endproperty
   a_mid_edge: assert property (p_mid_edge) else $error("no mid-bit transition on transmit"); // R02

   property p_rx_flags;
      rx_valid |-> rx_word.parity_ok == ^d_sh && rx_word.data == d_sh[16:1] && rx_word.sync_cmd == d_cmd;
   endproperty
   a_rx_flags: assert property (p_rx_flags) else $error("received word flags disagree with bits"); // R03

   property p_tx_parity;
      load |=> (^tx_word) && tx_cmd == $past(next_word.sync_cmd);
   endproperty
   a_tx_parity: assert property (p_tx_parity) else $error("transmit parity or sync wrong"); // R04

   property p_status_clear;
      cmd_hit |=> !st_me && st_bcr == $past(is_bcast) && st_sr == $past(cond[COND_SR]);
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status not rebuilt on command"); // R10

   property p_msg_error;
      bad_word |=> st_me && m_state == M_GAP ##1 m_state == M_IDLE && msg_error && msg_done;
   endproperty
   a_msg_error: assert property (p_msg_error) else $error("message error not handled"); // R11

   property p_status_fields;
      load_status |=> tx_word[16:12] == own_addr && !tx_word[10] && tx_word[8:6] == 3'b000;
   endproperty
   a_status_fields: assert property (p_status_fields) else $error("status address or fixed bits wrong"); // R12

   property p_suppress;
      load_status |-> !st_me && !st_bcr;
   endproperty
   a_suppress: assert property (p_suppress) else $error("status sent for broadcast or error"); // R16

   property p_resp_window;
      load_status |-> quiet >= RESP_MIN_CYC && quiet <= RESP_MAX_CYC;
   endproperty
   a_resp_window: assert property (p_resp_window) else $error("status response outside time window"); // R23

   property p_manch_err;
      rx_valid && rx_word.manch_err |-> !cmd_hit && !is_data;
   endproperty
   a_manch_err: assert property (p_manch_err) else $error("word with Manchester error accepted"); // R27

   c_status_sent: cover property (load_status ##1 tx_en);
   c_broadcast:   cover property (cmd_hit && is_bcast);
   c_msg_error:   cover property (bad_word ##[1:4] msg_error);
   c_data_word:   cover property (data_valid ##[1:1000] msg_done);

endmodule

// File: tb/bus_ctrl_model.sv
// bus controller model: drives Manchester words onto the receiver pair
module bus_ctrl_model (
   input  wire logic clk,
   output logic      rx_hi,
   output logic      rx_lo
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rx_hi = 1'b0;
      rx_lo = 1'b0;
   end
   // one line level for n cycles; both high never happens
   task automatic lvl(input logic hi, input int n);
      rx_hi <= hi;
      rx_lo <= ~hi;
      repeat (n) @(posedge clk);
   endtask
   // bad[0] flips the parity, bad[1] drops the mid-bit transition of the parity cell
   task automatic send(input logic cmd_sync, input logic [15:0] d, input logic [1:0] bad);
      logic [16:0] w;
      w = {d, ~^d ^ bad[0]};
      lvl(~cmd_sync, 37);
      lvl(cmd_sync, 38);
      for (int i = 16; i >= 0; i--) begin
         lvl(w[i], 12);
         lvl(~w[i] ^ (bad[1] && i == 0), 13);
      end
   endtask
   // released bus goes back to the idle pair, both low
   task automatic idle();
      rx_hi <= 1'b0;
      rx_lo <= 1'b0;
   endtask
endmodule

// File: tb/word_codec_tb_top.sv
// self-checking bench of the word codec against a bus controller model
module word_codec_tb_top
   import word_codec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rx_hi, rx_lo, tx_hi, tx_lo, tx_drive, host_tx_ready, rx_valid;
   logic        cmd_valid, data_valid, msg_done, msg_error, bus_ctrl_taken;
   logic        rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, host_tx_valid = 1'b0;
   logic        rd_d = 1'b0, tx_seen = 1'b0, done_seen = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [15:0] data_word;
   logic [4:0]  sa;
   rx_word_s    rx_last;
   tx_word_s    host_tx = '0;
   rx_word_s    rx_word;
   cmd_s        cmd;
   logic [63:0] link_q[$], reg_q[$];
   int          errors = 0, n_compared = 0;

   bus_ctrl_model bc (.clk, .rx_hi, .rx_lo);
   word_codec dut (.clk, .rst_n, .rx_hi, .rx_lo, .tx_hi, .tx_lo, .tx_drive, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .host_tx_valid, .host_tx, .host_tx_ready, .rx_valid, .rx_word,
      .cmd_valid, .cmd, .data_valid, .data_word, .msg_done, .msg_error, .bus_ctrl_taken);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic print_verdict();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // expectation word: mask in the upper half, value in the lower
   task automatic cmp(input logic [31:0] got, input logic [63:0] e);
      n_compared++;
      if ((got & e[63:32]) !== e[31:0]) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got & e[63:32], e[31:0]);
      end
   endtask
   task automatic cmp_link(input logic [31:0] got);
      cmp(got, link_q.size() ? link_q.pop_front() : {32'hffffffff, 32'hx});
   endtask
   task automatic cmp_reg(input logic [31:0] got);
      cmp(got, reg_q.size() ? reg_q.pop_front() : {32'hffffffff, 32'hx});
   endtask

   always @(posedge clk) rd_d <= reg_rd;
   // sampled mid-cycle so registered pulses are settled
   always @(negedge clk) begin
      if (rst_n) begin
         if (cmd_valid) cmp_link(32'(cmd));
         if (data_valid) cmp_link({16'h0, data_word});
         if (msg_done) cmp_link({31'h0, msg_error});
         if (rd_d) cmp_reg(reg_rdata);
         if (rx_valid) rx_last = rx_word;
         if (msg_done) done_seen = 1'b1;
         if (tx_drive) tx_seen = 1'b1;
      end
   end

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      reg_q.push_back({m, e});
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask
   // waits for message end, then for any status reply to finish
   task automatic settle();
      int i;
      for (i = 0; i < 1500 && !done_seen; i++) @(posedge clk);
      repeat (4) @(posedge clk);
      for (i = 0; i < 600 && tx_drive; i++) @(posedge clk);
      if (!done_seen || tx_drive) begin
         errors++;
         print_verdict();
      end
      done_seen = 1'b0;
   endtask
   // intr injects a foreign command in the data phase to corrupt the message
   task automatic msg(input logic [15:0] c, input int n, input logic intr, input logic err, input logic tx);
      logic [15:0] d;
      tx_seen = 1'b0;
      bc.send(1'b1, c, 2'd0);
      repeat (n) begin
         d = 16'($urandom);
         link_q.push_back({32'hffff, 16'h0, d});
         bc.send(1'b0, d, 2'd0);
      end
      if (intr) bc.send(1'b1, 16'h3c61, 2'd0);
      link_q.push_back({32'h1, 31'h0, err});
      bc.idle();
      settle();
      cmp({31'h0, tx_seen}, {32'h1, 31'h0, tx});
   endtask
   task automatic rx_chk(input logic s, input logic [15:0] d, input logic [1:0] bad, input logic [2:0] e);
      rx_last = 'x;
      bc.send(s, d, bad);
      bc.idle();
      repeat (30) @(posedge clk);
      cmp(32'(rx_last), {32'h7ffff, 13'h0, d, e});
   endtask

   initial begin
      void'($urandom(32'h148542fe));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      wr(REG_CTRL, 32'h25);
      rd(REG_CTRL, 32'hffffffff, 32'h25);
      wr(REG_COND, 32'h1);
      rd(REG_COND, 32'hffffffff, 32'h1);
      rd(4'h2, 32'hffffffff, 32'h0);
      // a zero word count is the longest message the terminal takes
      link_q.push_back({32'hffffc1, 8'h0, 5'd5, 1'b0, 5'd3, 1'b0, 6'h20, 6'h0});
      msg(16'h2860, 32, 1'b0, 1'b0, 1'b1);
      rd(REG_STATUS, 32'hffff, 32'h2900);
      wr(REG_COND, 32'h11);
      for (int k = 0; k < 2; k++) begin
         sa = k ? MODE_SA_HI : MODE_SA_LO;
         link_q.push_back({32'hfff03f, 8'h0, 5'd5, 1'b1, sa, 1'b1, 6'h0, 5'd2, 1'b0});
         msg({5'd5, 1'b1, sa, 5'd2}, 0, 1'b0, 1'b0, 1'b1);
         cmp({31'h0, bus_ctrl_taken}, {32'h1, 32'h1});
      end
      rd(REG_STATUS, 32'hffff, 32'h2902);
      wr(REG_COND, 32'hf);
      link_q.push_back({32'hffffc1, 8'h0, 5'd31, 1'b0, 5'd3, 1'b0, 6'h1, 6'h1});
      msg(16'hf861, 1, 1'b0, 1'b0, 1'b0);
      rd(REG_STATUS, 32'hfffd, 32'h291d);
      link_q.push_back({32'hffffc1, 8'h0, 5'd5, 1'b0, 5'd3, 1'b0, 6'h2, 6'h0});
      msg(16'h2862, 1, 1'b1, 1'b1, 1'b0);
      rd(REG_STATUS, 32'hfffd, 32'h2d0d);
      rx_chk(1'b0, 16'($urandom), 2'd1, 3'b000);
      rx_chk(1'b1, 16'h4c61, 2'd0, 3'b110);
      // own address, so only the Manchester error keeps it from being taken
      rx_chk(1'b1, 16'h2860, 2'd2, 3'b111);
      @(negedge clk) cmp({31'h0, host_tx_ready}, {32'h1, 32'h1});
      @(posedge clk);
      host_tx <= '{data: 16'($urandom), sync_cmd: 1'b1};
      host_tx_valid <= 1'b1;
      @(posedge clk);
      host_tx_valid <= 1'b0;
      repeat (2) @(posedge clk);
      #1 cmp({29'h0, tx_drive, tx_hi, tx_lo}, {32'h7, 32'h5});
      repeat (37) @(posedge clk);
      #1 cmp({29'h0, tx_drive, tx_hi, tx_lo}, {32'h7, 32'h6});
      repeat (42) @(posedge clk);
      #1 cmp({29'h0, tx_drive, tx_hi, tx_lo}, {32'h7, 30'h1, host_tx.data[15], ~host_tx.data[15]});
      repeat (398) @(posedge clk);
      #1 cmp({29'h0, tx_drive, tx_hi, tx_lo}, {32'h7, 30'h1, ~^host_tx.data, ^host_tx.data});
      repeat (23) @(posedge clk);
      #1 cmp({29'h0, tx_drive, tx_hi, tx_lo}, {32'h7, 32'h0});
      // an expectation left over means a result never showed up
      cmp(32'(link_q.size() + reg_q.size()), {32'hffffffff, 32'h0});
      print_verdict();
   end
endmodule
